// ==== verilog/sftr_pkg.sv ====
// sftr_pkg: constants shared by the synthesizer frequency trim register bank
// assumes a host that presents seven address bits and eight data bits per access
package sftr_pkg;

    // ------------------------------------------------------------
    // widths and counts
    // ------------------------------------------------------------
    localparam int NUM_SYNTH = 4;
    localparam int TRIM_W = 32;
    localparam int RATIO_W = 34;
    localparam int DIV_W = 24;
    localparam int PHASE_STEPS = 256;

    // ------------------------------------------------------------
    // full eight bit register addresses and the seven bit local page address
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_TRIM_B3 = 8'h73;
    localparam logic [7:0] ADDR_TRIM_B2 = 8'h74;
    localparam logic [7:0] ADDR_TRIM_B1 = 8'h75;
    localparam logic [7:0] ADDR_TRIM_B0 = 8'h76;
    localparam logic [7:0] ADDR_FILT = 8'h77;
    localparam logic [7:0] ADDR_PHASE = 8'h78;
    localparam logic [7:0] ADDR_PAGE = 8'h7f;
    localparam logic [7:0] ADDR_DIV_B2 = 8'h86;
    localparam logic [7:0] ADDR_DIV_B1 = 8'h87;
    localparam logic [7:0] ADDR_DIV_B0 = 8'h88;
    localparam logic [7:0] UPPER_FIRST = 8'h80;
    localparam logic [7:0] UPPER_LAST = 8'hfb;
    localparam logic [6:0] LOCAL_PAGE = 7'h7f;

    // ------------------------------------------------------------
    // reset values and field positions
    // ------------------------------------------------------------
    localparam logic [31:0] TRIM_RST = 32'h046aaaab;
    localparam logic [23:0] DIV_RST = 24'h00003c;
    localparam logic [7:0] PHASE_RST = 8'h00;
    localparam logic FILT_RST = 1'h0;
    localparam logic PAGE_RST = 1'h0;
    localparam int FILT_BIT = 0;
    localparam int PAGE_BIT = 0;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // unity rate in the Q2.32 ratio word
    localparam logic [33:0] RATIO_ONE = 34'h100000000;

endpackage : sftr_pkg

// ==== verilog/sftr_rate_scale.sv ====
// sftr_rate_scale: turns the signed trim word into the rate ratio 1 + trim/2^32
// assumes the trim word is already a complete, committed value
`timescale 1ns/1ps
`default_nettype none

module sftr_rate_scale #(
    parameter int TRIM_W = sftr_pkg::TRIM_W
) (
    clk,
    rst,
    trim,
    ratio
);
    input wire logic clk;
    input wire logic rst;
    input wire logic [TRIM_W-1:0] trim;
    output logic [TRIM_W+1:0] ratio;

    typedef struct packed {
        logic [TRIM_W+1:0] ratio;
    } sftr_scale_s;

    sftr_scale_s st;
    sftr_scale_s next_st;

    // ------------------------------------------------------------
    // ratio arithmetic
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.ratio = sftr_pkg::RATIO_ONE + {{2{trim[TRIM_W-1]}}, trim};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st.ratio <= sftr_pkg::RATIO_ONE + {{2{sftr_pkg::TRIM_RST[31]}}, sftr_pkg::TRIM_RST};
        end else begin
            st <= next_st;
        end
    end

    assign ratio = st.ratio;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_ratio_follows;
        @(posedge clk) disable iff (rst)
        1'h1 |=> (ratio - sftr_pkg::RATIO_ONE) == {{2{$past(trim[TRIM_W-1])}}, $past(trim)};
    endproperty
    a_ratio_follows: assert property (p_ratio_follows) else $error("ratio not 1+trim");

endmodule : sftr_rate_scale

`default_nettype wire

// ==== verilog/sftr_regs.sv ====
// sftr_regs: synthesizer frequency trim, filter, phase advance and page registers
// assumes a host port on this clock: seven address bits, one-cycle write/read strobes
`timescale 1ns/1ps
`default_nettype none

module sftr_regs #(
    parameter int NUM_SYNTH = sftr_pkg::NUM_SYNTH
) (
    clk,
    rst,
    host_addr,
    host_wdata,
    host_wr,
    host_rd,
    host_rdata,
    host_rvalid,
    host_err,
    synth_trim,
    trim_load,
    rate_ratio,
    filt_internal,
    phase_advance,
    first_div,
    page_sel
);
    input wire logic clk;
    input wire logic rst;
    input wire logic [6:0] host_addr;
    input wire logic [7:0] host_wdata;
    input wire logic host_wr;
    input wire logic host_rd;
    output logic [7:0] host_rdata;
    output logic host_rvalid;
    output logic host_err;
    output logic [sftr_pkg::TRIM_W-1:0] synth_trim;
    output logic trim_load;
    output logic [sftr_pkg::RATIO_W-1:0] rate_ratio;
    output logic filt_internal;
    output logic [7:0] phase_advance;
    output logic [sftr_pkg::DIV_W-1:0] first_div;
    output logic page_sel;

    typedef struct packed {
        logic [31:0] stage;
        logic [31:0] trim;
        logic load;
        logic filt;
        logic [7:0] phase;
        logic page;
        logic [23:0] div;
        logic [7:0] rdata;
        logic rvalid;
        logic err;
    } sftr_regs_s;

    localparam sftr_regs_s ST_RST = '{
        stage: sftr_pkg::TRIM_RST,
        trim: sftr_pkg::TRIM_RST,
        load: 1'h0,
        filt: sftr_pkg::FILT_RST,
        phase: sftr_pkg::PHASE_RST,
        page: sftr_pkg::PAGE_RST,
        div: sftr_pkg::DIV_RST,
        rdata: sftr_pkg::READ_ZERO,
        rvalid: 1'h0,
        err: 1'h0
    };

    sftr_regs_s st;
    sftr_regs_s next_st;
    logic [7:0] full_addr;
    logic page_hit;
    logic mapped;

    // ------------------------------------------------------------
    // address extension
    // ------------------------------------------------------------
    assign page_hit = (host_addr == sftr_pkg::LOCAL_PAGE);
    assign full_addr = page_hit ? sftr_pkg::ADDR_PAGE : {st.page, host_addr};

    always_comb begin
        mapped = 1'h0;
        if (full_addr >= sftr_pkg::ADDR_TRIM_B3 && full_addr <= sftr_pkg::ADDR_PHASE) begin
            mapped = 1'h1;
        end
        if (full_addr == sftr_pkg::ADDR_PAGE) begin
            mapped = 1'h1;
        end
        if (full_addr >= sftr_pkg::ADDR_DIV_B2 && full_addr <= sftr_pkg::ADDR_DIV_B0) begin
            mapped = 1'h1;
        end
        if (full_addr > sftr_pkg::UPPER_LAST) begin
            mapped = 1'h0;
        end
    end

    // ------------------------------------------------------------
    // register writes and reads
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.load = 1'h0;
        next_st.rvalid = 1'h0;
        next_st.err = 1'h0;
        if (host_wr) begin
            next_st.err = !mapped;
            case (full_addr)
                sftr_pkg::ADDR_TRIM_B3: next_st.stage[31:24] = host_wdata;
                sftr_pkg::ADDR_TRIM_B2: next_st.stage[23:16] = host_wdata;
                sftr_pkg::ADDR_TRIM_B1: next_st.stage[15:8] = host_wdata;
                sftr_pkg::ADDR_TRIM_B0: begin
                    next_st.stage[7:0] = host_wdata;
                    next_st.trim = {st.stage[31:8], host_wdata};
                    next_st.load = 1'h1;
                end
                sftr_pkg::ADDR_FILT: next_st.filt = host_wdata[sftr_pkg::FILT_BIT];
                sftr_pkg::ADDR_PHASE: next_st.phase = host_wdata;
                sftr_pkg::ADDR_PAGE: next_st.page = host_wdata[sftr_pkg::PAGE_BIT];
                sftr_pkg::ADDR_DIV_B2: next_st.div[23:16] = host_wdata;
                sftr_pkg::ADDR_DIV_B1: next_st.div[15:8] = host_wdata;
                sftr_pkg::ADDR_DIV_B0: next_st.div[7:0] = host_wdata;
                default: next_st.stage = st.stage;
            endcase
        end else if (host_rd) begin
            next_st.rvalid = 1'h1;
            next_st.err = !mapped;
            case (full_addr)
                sftr_pkg::ADDR_TRIM_B3: next_st.rdata = st.stage[31:24];
                sftr_pkg::ADDR_TRIM_B2: next_st.rdata = st.stage[23:16];
                sftr_pkg::ADDR_TRIM_B1: next_st.rdata = st.stage[15:8];
                sftr_pkg::ADDR_TRIM_B0: next_st.rdata = st.stage[7:0];
                sftr_pkg::ADDR_FILT: next_st.rdata = {7'h00, st.filt};
                sftr_pkg::ADDR_PHASE: next_st.rdata = st.phase;
                sftr_pkg::ADDR_PAGE: next_st.rdata = {7'h00, st.page};
                sftr_pkg::ADDR_DIV_B2: next_st.rdata = st.div[23:16];
                sftr_pkg::ADDR_DIV_B1: next_st.rdata = st.div[15:8];
                sftr_pkg::ADDR_DIV_B0: next_st.rdata = st.div[7:0];
                default: next_st.rdata = sftr_pkg::READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= ST_RST;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // rate ratio for the nco view
    // ------------------------------------------------------------
    sftr_rate_scale #(
        .TRIM_W(sftr_pkg::TRIM_W)
    ) u_scale (
        .clk(clk),
        .rst(rst),
        .trim(st.trim),
        .ratio(rate_ratio)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign synth_trim = st.trim;
    assign trim_load = st.load;
    assign filt_internal = st.filt;
    assign phase_advance = st.phase;
    assign first_div = st.div;
    assign page_sel = st.page;
    assign host_rdata = st.rdata;
    assign host_rvalid = st.rvalid;
    assign host_err = st.err;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_wr_low(logic [6:0] a);
        host_wr && !page_sel && host_addr == a;
    endsequence

    sequence s_wr_high(logic [6:0] a);
        host_wr && page_sel && host_addr == a;
    endsequence

    property p_trim_commit;
        @(posedge clk) disable iff (rst)
        s_wr_low(sftr_pkg::ADDR_TRIM_B0[6:0]) |=>
            trim_load && synth_trim[7:0] == $past(host_wdata)
            ##1 (!trim_load || $past(host_wr && !page_sel
                && host_addr == sftr_pkg::ADDR_TRIM_B0[6:0]));
    endproperty
    a_trim_commit: assert property (p_trim_commit) else $error("trim not committed");

    property p_trim_hold;
        @(posedge clk) disable iff (rst)
        (s_wr_low(sftr_pkg::ADDR_TRIM_B3[6:0]) or s_wr_low(sftr_pkg::ADDR_TRIM_B1[6:0]))
            |=> $stable(synth_trim) && !trim_load;
    endproperty
    a_trim_hold: assert property (p_trim_hold) else $error("partial trim applied");

    property p_trim_word;
        @(posedge clk) disable iff (rst)
        s_wr_low(sftr_pkg::ADDR_TRIM_B1[6:0]) ##1 !host_wr
            ##1 s_wr_low(sftr_pkg::ADDR_TRIM_B0[6:0])
            |=> synth_trim[15:8] == $past(host_wdata, 3);
    endproperty
    a_trim_word: assert property (p_trim_word) else $error("trim byte lost");

    property p_ratio_tracks;
        @(posedge clk) disable iff (rst)
        trim_load |=> rate_ratio ==
            sftr_pkg::RATIO_ONE + {{2{$past(synth_trim[31])}}, $past(synth_trim)};
    endproperty
    a_ratio_tracks: assert property (p_ratio_tracks) else $error("ratio lags trim");

    property p_filter;
        @(posedge clk) disable iff (rst)
        s_wr_low(sftr_pkg::ADDR_FILT[6:0]) |=> filt_internal == $past(host_wdata[0]);
    endproperty
    a_filter: assert property (p_filter) else $error("filter select wrong");

    property p_phase;
        @(posedge clk) disable iff (rst)
        s_wr_low(sftr_pkg::ADDR_PHASE[6:0]) |=> phase_advance == $past(host_wdata);
    endproperty
    a_phase: assert property (p_phase) else $error("phase advance wrong");

    property p_page;
        @(posedge clk) disable iff (rst)
        host_wr && host_addr == sftr_pkg::LOCAL_PAGE |=> page_sel == $past(host_wdata[0]);
    endproperty
    a_page: assert property (p_page) else $error("page select wrong");

    property p_upper_div;
        @(posedge clk) disable iff (rst)
        s_wr_high(sftr_pkg::ADDR_DIV_B2[6:0]) |=> first_div[23:16] == $past(host_wdata);
    endproperty
    a_upper_div: assert property (p_upper_div) else $error("upper half not reached");

    property p_upper_end;
        @(posedge clk) disable iff (rst)
        host_rd && !host_wr && page_sel && host_addr > sftr_pkg::UPPER_LAST[6:0]
            && host_addr != sftr_pkg::LOCAL_PAGE
            |=> host_rvalid && host_err && host_rdata == sftr_pkg::READ_ZERO;
    endproperty
    a_upper_end: assert property (p_upper_end) else $error("decode past 0xfb");

    property p_read_phase;
        @(posedge clk) disable iff (rst)
        host_rd && !host_wr && !page_sel && host_addr == sftr_pkg::ADDR_PHASE[6:0]
            |=> host_rvalid && host_rdata == $past(phase_advance);
    endproperty
    a_read_phase: assert property (p_read_phase) else $error("phase readback wrong");

    property p_filt_read;
        @(posedge clk) disable iff (rst)
        host_rd && !host_wr && !page_sel && host_addr == sftr_pkg::ADDR_FILT[6:0]
            |=> host_rvalid && host_rdata == {7'h00, $past(filt_internal)};
    endproperty
    a_filt_read: assert property (p_filt_read) else $error("filter readback wrong");

    property p_write_refused;
        @(posedge clk) disable iff (rst)
        host_wr && !mapped |=> host_err && $stable(synth_trim) && $stable(phase_advance)
            && $stable(filt_internal) && $stable(first_div) && $stable(page_sel);
    endproperty
    a_write_refused: assert property (p_write_refused) else $error("bad write landed");

    property p_upper_div_low;
        @(posedge clk) disable iff (rst)
        s_wr_high(sftr_pkg::ADDR_DIV_B0[6:0]) |=> first_div[7:0] == $past(host_wdata);
    endproperty
    a_upper_div_low: assert property (p_upper_div_low) else $error("divider low lost");

    property p_stage_read;
        @(posedge clk) disable iff (rst)
        host_rd && !host_wr && !page_sel && host_addr == sftr_pkg::ADDR_TRIM_B3[6:0]
            |=> host_rvalid && host_rdata == $past(st.stage[31:24]);
    endproperty
    a_stage_read: assert property (p_stage_read) else $error("staged byte wrong");

    property p_no_answer;
        @(posedge clk) disable iff (rst)
        !(host_rd && !host_wr) |=> !host_rvalid;
    endproperty
    a_no_answer: assert property (p_no_answer) else $error("answer without read");

endmodule : sftr_regs

`default_nettype wire

// ==== tb/sftr_host_model.sv ====
// sftr_host_model: host side of the register port, byte reads and writes
// assumes the bench clock and the one-cycle strobe port of sftr_regs
`timescale 1ns/1ps
`default_nettype none

module sftr_host_model (
    clk,
    host_addr,
    host_wdata,
    host_wr,
    host_rd,
    host_rdata,
    host_rvalid,
    host_err
);
    input wire logic clk;
    output logic [6:0] host_addr;
    output logic [7:0] host_wdata;
    output logic host_wr;
    output logic host_rd;
    input wire logic [7:0] host_rdata;
    input wire logic host_rvalid;
    input wire logic host_err;

    logic page;

    initial begin
        host_addr = 7'h55;
        host_wdata = 8'haa;
        host_wr = 1'b0;
        host_rd = 1'b0;
        page = 1'b0;
    end

    // ----
    // one strobe, lines scrambled when idle
    // ----
    task automatic pulse(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(posedge clk);
        host_addr <= a[6:0];
        host_wdata <= d;
        host_wr <= w;
        host_rd <= !w;
        @(posedge clk);
        host_addr <= ~a[6:0];
        host_wdata <= ~d;
        host_wr <= 1'b0;
        host_rd <= 1'b0;
        #1;
    endtask : pulse

    // full eight bit access, page set first when crossing halves
    task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w,
                          output logic [7:0] q, output logic v, output logic e);
        if (a[6:0] != 7'h7f && a[7] !== page) begin
            pulse(8'h7f, {7'h00, a[7]}, 1'b1);
            page = a[7];
        end
        pulse(a, d, w);
        if (a[6:0] == 7'h7f && w) begin
            page = d[0];
        end
        q = host_rdata;
        v = host_rvalid;
        e = host_err;
    endtask : access
endmodule : sftr_host_model

`default_nettype wire

// ==== tb/sftr_regs_bench.sv ====
// sftr_regs_bench: self-checking bench for the trim register bank
// assumes sftr_regs and sftr_host_model are compiled before it
`timescale 1ns/1ps
`default_nettype none

module sftr_regs_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [6:0] host_addr;
    logic [7:0] host_wdata;
    logic host_wr;
    logic host_rd;
    logic [7:0] host_rdata;
    logic host_rvalid;
    logic host_err;
    logic [31:0] synth_trim;
    logic trim_load;
    logic [33:0] rate_ratio;
    logic filt_internal;
    logic [7:0] phase_advance;
    logic [23:0] first_div;
    logic page_sel;
    int n_fail = 0;
    int comparisons = 0;
    logic [31:0] tv [3] = '{32'h0539782a, 32'hfafafafb, 32'h00000000};

    always #4 clk = ~clk;

    sftr_regs sftr_regs_i (.clk(clk), .rst(rst), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
        .host_rdata(host_rdata), .host_rvalid(host_rvalid), .host_err(host_err),
        .synth_trim(synth_trim), .trim_load(trim_load), .rate_ratio(rate_ratio),
        .filt_internal(filt_internal), .phase_advance(phase_advance),
        .first_div(first_div), .page_sel(page_sel));

    sftr_host_model sftr_host_model_i (.clk(clk), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
        .host_rdata(host_rdata), .host_rvalid(host_rvalid), .host_err(host_err));

    // ----
    // compare and access tasks
    // ----
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic ee);
        logic [7:0] q;
        logic v;
        logic e;
        sftr_host_model_i.access(a, 8'h00, 1'b0, q, v, e);
        check(v, 1'b1);
        check(q, exp);
        check(e, ee);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ee);
        logic [7:0] q;
        logic v;
        logic e;
        sftr_host_model_i.access(a, d, 1'b1, q, v, e);
        check(e, ee);
    endtask : wr

    initial begin
        #100000;
        n_fail++;
        final_report();
    end

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        check(synth_trim, sftr_pkg::TRIM_RST);
        check(rate_ratio, 34'h1046aaaab);
        check(first_div, 24'h00003c);
        for (int i = 0; i < 4; i++) begin
            rd(8'h73 + 8'(i), sftr_pkg::TRIM_RST[31-8*i -: 8], 1'b0);
        end
        rd(8'h77, 8'h00, 1'b0);
        rd(8'h78, 8'h00, 1'b0);
        rd(8'h7f, 8'h00, 1'b0);
        $display("reset values done");

        foreach (tv[k]) begin
            for (int i = 0; i < 3; i++) begin
                wr(8'h73 + 8'(i), tv[k][31-8*i -: 8], 1'b0);
                check(synth_trim, k == 0 ? sftr_pkg::TRIM_RST : tv[k-1]);
                check(trim_load, 1'b0);
            end
            wr(8'h76, tv[k][7:0], 1'b0);
            check(trim_load, 1'b1);
            check(synth_trim, tv[k]);
            @(posedge clk);
            #1;
            check(trim_load, 1'b0);
            check(rate_ratio, 34'h100000000 + {{2{tv[k][31]}}, tv[k]});
        end
        $display("trim word done");

        wr(8'h77, 8'hff, 1'b0);
        check(filt_internal, 1'b1);
        rd(8'h77, 8'h01, 1'b0);
        wr(8'h77, 8'hfe, 1'b0);
        check(filt_internal, 1'b0);
        wr(8'h78, 8'hc3, 1'b0);
        check(phase_advance, 8'hc3);
        rd(8'h78, 8'hc3, 1'b0);
        wr(8'h79, 8'h55, 1'b1);
        check(phase_advance, 8'hc3);
        $display("filter and phase done");

        wr(8'h86, 8'h12, 1'b0);
        check(page_sel, 1'b1);
        wr(8'h87, 8'h34, 1'b0);
        wr(8'h88, 8'h56, 1'b0);
        check(first_div, 24'h123456);
        rd(8'h86, 8'h12, 1'b0);
        rd(8'hfb, 8'h00, 1'b1);
        rd(8'hfc, 8'h00, 1'b1);
        rd(8'h7f, 8'h01, 1'b0);
        rd(8'h10, 8'h00, 1'b1);
        check(page_sel, 1'b0);
        check(first_div, 24'h123456);
        $display("page select done");

        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        check(page_sel, 1'b0);
        check(synth_trim, sftr_pkg::TRIM_RST);
        check(first_div, sftr_pkg::DIV_RST);
        check(phase_advance, 8'h00);
        check(filt_internal, 1'b0);
        $display("mid-run reset done");
        final_report();
    end
endmodule : sftr_regs_bench

`default_nettype wire
